// file: stu_pkg.sv
// Purpose: Shared constants and types of the servo timer unit, plus one PWM channel.
// Assumes: clk_sys at 25 MHz, synchronous active-high reset.
// Notes:   The PWM channel is instantiated six times by the top module.
package stu_pkg;
  localparam int CLK_NS        = 40;
  localparam int TM_RES_NS     = 1000;   // Head, frame, duty and interval-a timers
  localparam int TM_SLOW_RES_NS = 2000;  // Remote decode and interval-b timers
  localparam int FRC_RES_NS    = 125;
  localparam int CARRIER_NS    = 16000;  // 128 internal clocks at 8 MHz
  localparam int TICK_FAST_CYC = (TM_RES_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_SLOW_CYC = (TM_SLOW_RES_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_FRC_CYC  = (FRC_RES_NS + CLK_NS - 1) / CLK_NS;
  localparam int CARRIER_CYC   = CARRIER_NS / CLK_NS;

  localparam int PRE_W   = 6;
  localparam int CAR_W   = 9;
  localparam int TM_W    = 16;
  localparam int EVT_W   = 8;
  localparam int FRC_W   = 22;
  localparam int TAPE_W  = 5;
  localparam int PWM_HI_W = 16;
  localparam int PWM_LO_W = 8;
  localparam int NUM_PWM_GRP = 3;
  localparam int NUM_CAP = 6;
  localparam int NUM_IRQ = 6;
  localparam int NUM_RTP = 4;

  localparam logic [PRE_W-1:0] TICK_FAST_LAST = PRE_W'(TICK_FAST_CYC - 1);
  localparam logic [PRE_W-1:0] TICK_SLOW_LAST = PRE_W'(TICK_SLOW_CYC - 1);
  localparam logic [PRE_W-1:0] TICK_FRC_LAST  = PRE_W'(TICK_FRC_CYC - 1);
  localparam logic [CAR_W-1:0] CARRIER_LAST   = CAR_W'(CARRIER_CYC - 1);

  // Interrupt pending bit positions
  localparam int IRQ_HEAD    = 0;
  localparam int IRQ_FRAME_D = 1;
  localparam int IRQ_INT_A   = 2;
  localparam int IRQ_REMOTE  = 3;
  localparam int IRQ_INT_B   = 4;
  localparam int IRQ_TAPE    = 5;
  // Real-time port trigger positions: 0..2 head compares, 3 frame compare d
  localparam int RTP_FRAME_D = 3;

  typedef struct packed {
    logic             drum_pg;
    logic             drum_fg;
    logic [NUM_CAP-1:0] cap_trig;
    logic             vsync;
    logic             playback_ctl_track;
    logic             cfg_pulse;
    logic             remote_edge_input;
  } stu_pins_t;

  typedef struct packed {
    logic [2:0][TM_W-1:0]  head_timer_cmp;
    logic [3:0][EVT_W-1:0] event_cmp;
    logic [2:0][TM_W-1:0]  frame_ref_cmp;      // a, b, d
    logic                  frame_d_to_rtp;     // 1: trigger port, 0: unmask vsync
    logic [1:0][TM_W-1:0]  ctl_duty_cmp;
    logic [EVT_W-1:0]      event_divider_cmp;
    logic [TM_W-1:0]       interval_a_cmp;
    logic [TM_W-1:0]       interval_b_cmp;
    logic [TAPE_W-1:0]     tape_counter_cmp;
    logic [NUM_PWM_GRP-1:0][PWM_HI_W-1:0] duty_hi;
    logic [NUM_PWM_GRP-1:0][PWM_LO_W-1:0] duty_lo;
  } stu_cfg_t;

  typedef struct packed {
    logic [PRE_W-1:0]      pre_fast;
    logic [PRE_W-1:0]      pre_slow;
    logic [PRE_W-1:0]      pre_frc;
    logic [CAR_W-1:0]      carrier;
    logic [TM_W-1:0]       head_switch_timer;
    logic [EVT_W-1:0]      drum_event_counter;
    logic [2:0]            head_match;
    logic [3:0]            event_match;
    logic [FRC_W-1:0]      free_run_counter;
    logic [NUM_CAP-1:0][FRC_W-1:0] free_run_capture;
    logic [TM_W-1:0]       frame_ref_timer;
    logic [TM_W-1:0]       frame_ref_capture;
    logic [2:0]            frame_match;
    logic [TM_W-1:0]       ctl_duty_timer;
    logic [TM_W-1:0]       ctl_duty_capture;
    logic [1:0]            ctl_match;
    logic [EVT_W-1:0]      event_divider;
    logic                  event_divider_out;
    logic [TM_W-1:0]       interval_timer_a;
    logic [TM_W-1:0]       remote_decode_timer;
    logic [TM_W-1:0]       remote_cap_cmp;
    logic [TM_W-1:0]       remote_capture;
    logic [TM_W-1:0]       interval_timer_b;
    logic [TAPE_W-1:0]     tape_updown_counter;
    logic [NUM_RTP-1:0]    realtime_out_port_trig;
    logic                  vsync_unmask;
    logic [NUM_IRQ-1:0]    irq_pend;
  } stu_state_t;
endpackage

// One PWM line: high while the carrier phase is below the scaled duty value.
module stu_pwm_chan
  import stu_pkg::*;
#(
  parameter int W = PWM_HI_W
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [CAR_W-1:0] carrier,
  input  wire logic [W-1:0]     duty,
  output logic                  pwm_r
);
  logic [CAR_W+W-1:0] phase_scaled;
  logic [CAR_W+W-1:0] duty_scaled;
  logic               pwm_nxt;

  // Scaling by the carrier length keeps full duty resolution on a non power of two period
  always_comb begin
    phase_scaled = {carrier, {W{1'b0}}};
    duty_scaled  = (CAR_W+W)'(duty) * (CAR_W+W)'(CARRIER_CYC);
    pwm_nxt      = phase_scaled < duty_scaled;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= pwm_nxt;
    end
  end
endmodule

// file: stu_servo_plant.sv
// Purpose: Drum, tape and remote signal source facing the timer unit.
// Assumes: Levels change just after a rising clock edge.
// Notes:   Callers hold each level one clock at least, or the edge is lost.
module stu_servo_plant
  import stu_pkg::*;
(
  input wire logic clk_sys,
  output stu_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = '0;
  task automatic level(input int idx, input logic v);
    @(posedge clk_sys) pins[idx] <= v;
  endtask
endmodule

// file: stu_servo_timer.sv
// Purpose: Servo timer unit: head, free-run, frame, interval, remote, tape and PWM timers.
// Assumes: Pins are asynchronous and pass two flip-flops; config comes from same-clock logic.
// Notes:   No bus; compare values arrive on cfg, counts and captures leave on timer_state.

// Contract
// - Head group: 8-bit event counter, 16-bit timer.
// - Head timer compare matches trigger realtime port.
// - Six free-run captures latch counter on rising edges.
// - Frame group: three timers/dividers with compares, captures.
// - Frame compare d unmasks vsync or triggers port.
// - Interval timer a clears on match, interrupts.
// - Remote edge captures timer into both registers.
// - Interval timer b clears on match, interrupts.
// - Tape counter up on rise, down on fall.
// - Tape counter interrupts on equal or underflow.
// - Three 16-bit and three 8-bit PWM outputs.
// - PWM carrier period equals 16 microseconds.
// - Tape up/down counter is five bits.
// - Free-run counter advances every 4 clocks, 160 ns.
module stu_servo_timer
  import stu_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire stu_pins_t          pins,
  input  wire stu_cfg_t           cfg,
  input  wire logic [NUM_IRQ-1:0] irq_clear,
  output stu_state_t              timer_state,
  output logic [NUM_IRQ-1:0]      irq_pend,
  output logic [NUM_RTP-1:0]      realtime_out_port_trig,
  output logic                    vsync_unmask,
  output logic [NUM_PWM_GRP-1:0]  pwm_hi,
  output logic [NUM_PWM_GRP-1:0]  pwm_lo
);
  localparam int PIN_W = $bits(stu_pins_t);

  logic [PIN_W-1:0] sync1_r;
  logic [PIN_W-1:0] sync2_r;
  logic [PIN_W-1:0] sync3_r;
  stu_pins_t        pin_now;
  stu_pins_t        pin_old;
  stu_pins_t        rise;
  stu_pins_t        fall;
  stu_state_t       st_r;
  stu_state_t       st_nxt;
  logic             tick_fast;
  logic             tick_slow;
  logic             tick_frc;
  logic             remote_edge;
  logic [NUM_IRQ-1:0] irq_set;

  // Only the second stage is looked at; the third holds the previous level for edges
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  always_comb begin
    pin_now     = stu_pins_t'(sync2_r);
    pin_old     = stu_pins_t'(sync3_r);
    rise        = stu_pins_t'(sync2_r & ~sync3_r);
    fall        = stu_pins_t'(~sync2_r & sync3_r);
    remote_edge = pin_now.remote_edge_input != pin_old.remote_edge_input;
    tick_fast   = st_r.pre_fast == TICK_FAST_LAST;
    tick_slow   = st_r.pre_slow == TICK_SLOW_LAST;
    tick_frc    = st_r.pre_frc == TICK_FRC_LAST;
  end

  always_comb begin
    st_nxt  = st_r;
    irq_set = '0;

    // Prescalers and PWM carrier
    st_nxt.pre_fast = tick_fast ? '0 : st_r.pre_fast + 1'b1;
    st_nxt.pre_slow = tick_slow ? '0 : st_r.pre_slow + 1'b1;
    st_nxt.pre_frc  = tick_frc  ? '0 : st_r.pre_frc + 1'b1;
    st_nxt.carrier  = (st_r.carrier == CARRIER_LAST) ? '0 : st_r.carrier + 1'b1;

    // Head group: timer restarts on drum phase, event counter counts drum speed pulses
    st_nxt.head_match  = '0;
    st_nxt.event_match = '0;
    if (rise.drum_pg) begin
      st_nxt.head_switch_timer  = '0;
      st_nxt.drum_event_counter = '0;
    end else begin
      if (tick_fast) begin
        st_nxt.head_switch_timer = st_r.head_switch_timer + 1'b1;
      end
      if (rise.drum_fg) begin
        st_nxt.drum_event_counter = st_r.drum_event_counter + 1'b1;
      end
    end
    for (int i = 0; i < 3; i++) begin
      st_nxt.head_match[i] = tick_fast && st_r.head_switch_timer == cfg.head_timer_cmp[i];
    end
    for (int i = 0; i < 4; i++) begin
      st_nxt.event_match[i] = rise.drum_fg && st_nxt.drum_event_counter == cfg.event_cmp[i];
    end
    irq_set[IRQ_HEAD] = st_nxt.head_match[0];

    // Free-running counter and its captures
    if (tick_frc) begin
      st_nxt.free_run_counter = st_r.free_run_counter + 1'b1;
    end
    for (int i = 0; i < NUM_CAP; i++) begin
      if (rise.cap_trig[i]) begin
        st_nxt.free_run_capture[i] = st_r.free_run_counter;
      end
    end

    // Frame reference timer: restarts on vsync, captures on control track rise
    st_nxt.frame_match = '0;
    if (rise.vsync) begin
      st_nxt.frame_ref_timer = '0;
    end else if (tick_fast) begin
      st_nxt.frame_ref_timer = st_r.frame_ref_timer + 1'b1;
    end
    if (rise.playback_ctl_track) begin
      st_nxt.frame_ref_capture = st_r.frame_ref_timer;
    end
    for (int i = 0; i < 3; i++) begin
      st_nxt.frame_match[i] = tick_fast && st_r.frame_ref_timer == cfg.frame_ref_cmp[i];
    end
    st_nxt.realtime_out_port_trig = {st_nxt.frame_match[2] && cfg.frame_d_to_rtp,
                                     st_nxt.head_match};
    st_nxt.vsync_unmask = st_nxt.frame_match[2] && !cfg.frame_d_to_rtp;
    irq_set[IRQ_FRAME_D] = st_nxt.frame_match[2];

    // Control-track duty timer: period capture restarts the count
    st_nxt.ctl_match = '0;
    if (rise.playback_ctl_track) begin
      st_nxt.ctl_duty_capture = st_r.ctl_duty_timer;
      st_nxt.ctl_duty_timer   = '0;
    end else if (tick_fast) begin
      st_nxt.ctl_duty_timer = st_r.ctl_duty_timer + 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      st_nxt.ctl_match[i] = tick_fast && st_r.ctl_duty_timer == cfg.ctl_duty_cmp[i];
    end

    // Event divider on the capstan pulse
    st_nxt.event_divider_out = 1'b0;
    if (rise.cfg_pulse) begin
      if (st_r.event_divider == cfg.event_divider_cmp) begin
        st_nxt.event_divider     = '0;
        st_nxt.event_divider_out = 1'b1;
      end else begin
        st_nxt.event_divider = st_r.event_divider + 1'b1;
      end
    end

    // Interval timer a
    if (tick_fast) begin
      if (st_r.interval_timer_a == cfg.interval_a_cmp) begin
        st_nxt.interval_timer_a = '0;
        irq_set[IRQ_INT_A]      = 1'b1;
      end else begin
        st_nxt.interval_timer_a = st_r.interval_timer_a + 1'b1;
      end
    end

    // Remote decode timer runs free; both edges capture it
    if (tick_slow) begin
      st_nxt.remote_decode_timer = st_r.remote_decode_timer + 1'b1;
    end
    if (remote_edge) begin
      st_nxt.remote_cap_cmp = st_r.remote_decode_timer;
      st_nxt.remote_capture = st_r.remote_decode_timer;
      irq_set[IRQ_REMOTE]   = 1'b1;
    end

    // Interval timer b
    if (tick_slow) begin
      if (st_r.interval_timer_b == cfg.interval_b_cmp) begin
        st_nxt.interval_timer_b = '0;
        irq_set[IRQ_INT_B]      = 1'b1;
      end else begin
        st_nxt.interval_timer_b = st_r.interval_timer_b + 1'b1;
      end
    end

    // Tape counter: zero wraps to all ones on a falling edge and flags underflow
    if (rise.playback_ctl_track) begin
      st_nxt.tape_updown_counter = st_r.tape_updown_counter + 1'b1;
    end else if (fall.playback_ctl_track) begin
      st_nxt.tape_updown_counter = st_r.tape_updown_counter - 1'b1;
      if (st_r.tape_updown_counter == '0) begin
        irq_set[IRQ_TAPE] = 1'b1;
      end
    end
    if ((rise.playback_ctl_track || fall.playback_ctl_track) &&
        st_nxt.tape_updown_counter == cfg.tape_counter_cmp) begin
      irq_set[IRQ_TAPE] = 1'b1;
    end

    // A new event beats a clear in the same cycle
    st_nxt.irq_pend = (st_r.irq_pend & ~irq_clear) | irq_set;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    timer_state            = st_r;
    irq_pend               = st_r.irq_pend;
    realtime_out_port_trig = st_r.realtime_out_port_trig;
    vsync_unmask           = st_r.vsync_unmask;
  end

  // PWM lines share the carrier so all six stay phase aligned
  for (genvar g = 0; g < NUM_PWM_GRP; g++) begin : g_pwm
    stu_pwm_chan #(.W(PWM_HI_W)) u_hi (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .carrier (st_r.carrier),
      .duty    (cfg.duty_hi[g]),
      .pwm_r   (pwm_hi[g])
    );
    stu_pwm_chan #(.W(PWM_LO_W)) u_lo (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .carrier (st_r.carrier),
      .duty    (cfg.duty_lo[g]),
      .pwm_r   (pwm_lo[g])
    );
  end
endmodule

// file: stu_servo_timer_props.sv
// Purpose: Port assertions for the servo timer unit.
// Assumes: Config fields change only between scenarios.
// Notes:   Bound to the top module; pin edges act three clocks late.
module stu_servo_timer_props
  import stu_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire stu_pins_t          pins,
  input wire stu_cfg_t           cfg,
  input wire logic [NUM_IRQ-1:0] irq_clear,
  input wire stu_state_t         timer_state,
  input wire logic [NUM_IRQ-1:0] irq_pend,
  input wire logic [NUM_RTP-1:0] realtime_out_port_trig,
  input wire logic               vsync_unmask,
  input wire logic [2:0]         pwm_hi,
  input wire logic [2:0]         pwm_lo
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_frc_idle;
    $stable(timer_state.free_run_counter) [*3];
  endsequence
  sequence s_remote_edge;
    $changed(pins.remote_edge_input) && irq_clear == '0;
  endsequence
  chk_int_a_clear: assert property ($rose(irq_pend[IRQ_INT_A]) |-> ##[0:1] timer_state.interval_timer_a == '0)
    else $error("interval a kept counting past its match");
  chk_int_b_clear: assert property ($rose(irq_pend[IRQ_INT_B]) |-> ##[0:1] timer_state.interval_timer_b == '0)
    else $error("interval b kept counting past its match");
  chk_remote_pair: assert property (timer_state.remote_cap_cmp == timer_state.remote_capture)
    else $error("remote captures differ");
  chk_remote_irq: assert property (s_remote_edge |-> ##[2:4] irq_pend[IRQ_REMOTE])
    else $error("remote edge raised no request");
  chk_tape_step: assert property ($changed(timer_state.tape_updown_counter) |->
    timer_state.tape_updown_counter == $past(timer_state.tape_updown_counter) + 5'd1 ||
    timer_state.tape_updown_counter == $past(timer_state.tape_updown_counter) - 5'd1)
    else $error("tape counter jumped");
  chk_tape_irq: assert property ($changed(timer_state.tape_updown_counter) &&
    timer_state.tape_updown_counter == cfg.tape_counter_cmp |-> ##[0:1] irq_pend[IRQ_TAPE])
    else $error("tape match raised no request");
  chk_pend_hold: assert property ((($past(irq_pend) & ~irq_pend & ~$past(irq_clear)) == '0))
    else $error("pending flag dropped without clear");
  chk_trig_pulse: assert property (|realtime_out_port_trig |=> realtime_out_port_trig == '0)
    else $error("port trigger longer than one cycle");
  chk_frame_unmask: assert property (vsync_unmask |-> !$past(cfg.frame_d_to_rtp))
    else $error("unmask while port selected");
  chk_frame_rtp: assert property (realtime_out_port_trig[RTP_FRAME_D] |-> $past(cfg.frame_d_to_rtp))
    else $error("frame trigger while unmask selected");
  chk_frc_step: assert property ($changed(timer_state.free_run_counter) |->
    timer_state.free_run_counter == $past(timer_state.free_run_counter) + 1'b1 ##1 s_frc_idle)
    else $error("free-run counter stepped wrongly");
  chk_pwm_zero: assert property (pwm_lo[0] |-> $past(cfg.duty_lo[0]) != '0)
    else $error("pwm high with zero duty");
endmodule

bind stu_servo_timer stu_servo_timer_props i_props (.clk_sys, .sys_rst, .pins, .cfg, .irq_clear, .timer_state,
  .irq_pend, .realtime_out_port_trig, .vsync_unmask, .pwm_hi, .pwm_lo);

// file: tb.sv
// Purpose: Self-checking bench of the servo timer unit.
// Assumes: 25 MHz clock, config driven at clock edges.
// Notes:   Expected counts follow from the package tick constants.
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb
  import stu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P_REMOTE = 0;
  localparam int P_CFG    = 1;
  localparam int P_FG     = 10;
  localparam int P_CTL    = 2;
  localparam int P_VSYNC  = 3;
  localparam int P_CAP    = 4;
  localparam int P_PG     = 11;
  logic                   clk_sys;
  logic                   sys_rst;
  stu_pins_t              pins;
  stu_cfg_t               cfg;
  logic [NUM_IRQ-1:0]     irq_clear;
  stu_state_t             st;
  logic [NUM_IRQ-1:0]     irq_pend;
  logic [NUM_RTP-1:0]     realtime_out_port;
  logic                   vsync_unmask;
  logic [NUM_PWM_GRP-1:0] pwm_hi;
  logic [NUM_PWM_GRP-1:0] pwm_lo;
  int                     n_mismatch;
  int                     comparisons;

  stu_servo_plant i_plant (.clk_sys(clk_sys), .pins(pins));
  stu_servo_timer i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins), .cfg(cfg), .irq_clear(irq_clear),
    .timer_state(st), .irq_pend(irq_pend), .realtime_out_port_trig(realtime_out_port), .vsync_unmask(vsync_unmask),
    .pwm_hi(pwm_hi), .pwm_lo(pwm_lo));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Six clocks cover the synchroniser and the registered copy
  task automatic edge_pin(input int idx, input logic v);
    i_plant.level(idx, v);
    cyc(6);
  endtask
  task automatic clr_irq(input int b);
    @(posedge clk_sys) irq_clear[b] <= 1'b1;
    @(posedge clk_sys) irq_clear[b] <= 1'b0;
    #1;
  endtask
  task automatic irq_period(input int b, input int exp, input string nm);
    int n;
    clr_irq(b);
    for (n = 0; n < 400 && irq_pend[b] !== 1'b1; n++) cyc(1);
    cyc(10);
    `CHK(nm, 1'b1, irq_pend[b])
    clr_irq(b);
    for (n = 12; n < 400 && irq_pend[b] !== 1'b1; n++) cyc(1);
    `CHK(nm, exp, n)
  endtask
  task automatic t_intervals;
    @(posedge clk_sys) begin
      cfg.interval_a_cmp <= 16'h0003;
      cfg.interval_b_cmp <= 16'h0001;
    end
    irq_period(IRQ_INT_A, 4 * TICK_FAST_CYC, "interval_a");
    irq_period(IRQ_INT_B, 2 * TICK_SLOW_CYC, "interval_b");
  endtask
  task automatic t_remote;
    logic [TM_W-1:0] c0;
    clr_irq(IRQ_REMOTE);
    edge_pin(P_REMOTE, 1'b1);
    c0 = st.remote_capture;
    `CHK("remote_irq", 1'b1, irq_pend[IRQ_REMOTE])
    cyc(193);
    edge_pin(P_REMOTE, 1'b0);
    `CHK("remote_delta", 200 / TICK_SLOW_CYC, TM_W'(st.remote_capture - c0))
    `CHK("remote_pair", TM_W'(c0 + 200 / TICK_SLOW_CYC), st.remote_cap_cmp)
  endtask
  task automatic t_capture;
    i_plant.level(P_CAP, 1'b1);
    cyc(99);
    edge_pin(P_CAP + 1, 1'b1);
    `CHK("cap_delta", 100 / TICK_FRC_CYC, FRC_W'(st.free_run_capture[1] - st.free_run_capture[0]))
    edge_pin(P_CAP, 1'b0);
    edge_pin(P_CAP + 1, 1'b0);
  endtask
  task automatic t_tape;
    @(posedge clk_sys) cfg.tape_counter_cmp <= 5'h01;
    clr_irq(IRQ_TAPE);
    edge_pin(P_CTL, 1'b1);
    `CHK("tape_up", 5'h01, st.tape_updown_counter)
    `CHK("tape_irq_up", 1'b1, irq_pend[IRQ_TAPE])
    @(posedge clk_sys) cfg.tape_counter_cmp <= 5'h00;
    clr_irq(IRQ_TAPE);
    edge_pin(P_CTL, 1'b0);
    `CHK("tape_down", 5'h00, st.tape_updown_counter)
    `CHK("tape_irq_down", 1'b1, irq_pend[IRQ_TAPE])
  endtask
  task automatic t_frame;
    int n;
    @(posedge clk_sys) begin
      cfg.head_timer_cmp[0] <= 16'h0002;
      cfg.frame_ref_cmp[2]  <= 16'h0004;
      cfg.frame_d_to_rtp    <= 1'b1;
    end
    clr_irq(IRQ_HEAD);
    clr_irq(IRQ_FRAME_D);
    edge_pin(P_PG, 1'b1);
    edge_pin(P_VSYNC, 1'b1);
    for (n = 0; n < 300 && realtime_out_port[0] !== 1'b1; n++) cyc(1);
    `CHK("head_trig", 1'b1, realtime_out_port[0])
    `CHK("head_irq", 1'b1, irq_pend[IRQ_HEAD])
    for (n = 0; n < 300 && realtime_out_port[RTP_FRAME_D] !== 1'b1; n++) cyc(1);
    `CHK("frame_trig", 1'b1, realtime_out_port[RTP_FRAME_D])
    `CHK("frame_irq", 1'b1, irq_pend[IRQ_FRAME_D])
    @(posedge clk_sys) cfg.frame_d_to_rtp <= 1'b0;
    edge_pin(P_VSYNC, 1'b0);
    edge_pin(P_VSYNC, 1'b1);
    for (n = 0; n < 300 && vsync_unmask !== 1'b1; n++) cyc(1);
    `CHK("unmask", 1'b1, vsync_unmask)
  endtask
  // Runs after the drum phase rise, so the event counter starts from zero
  task automatic t_events;
    @(posedge clk_sys) cfg.event_divider_cmp <= 8'h01;
    edge_pin(P_FG, 1'b1);
    `CHK("drum_events", 8'h01, st.drum_event_counter)
    edge_pin(P_CFG, 1'b1);
    `CHK("divider_step", 8'h01, st.event_divider)
    edge_pin(P_CFG, 1'b0);
    edge_pin(P_CFG, 1'b1);
    `CHK("divider_wrap", 8'h00, st.event_divider)
  endtask
  task automatic t_pwm;
    int n;
    int h_lo;
    int h_hi;
    int h_off;
    @(posedge clk_sys) begin
      cfg.duty_lo[0] <= 8'h80;
      cfg.duty_hi[1] <= 16'h4000;
    end
    #1;
    for (n = 0; n < 900 && pwm_lo[0] !== 1'b0; n++) cyc(1);
    for (n = 0; n < 900 && pwm_lo[0] !== 1'b1; n++) cyc(1);
    h_lo = 0;
    h_hi = 0;
    h_off = 0;
    for (n = 0; n < CARRIER_CYC; n++) begin
      h_lo += int'(pwm_lo[0] === 1'b1);
      h_hi += int'(pwm_hi[1] === 1'b1);
      h_off += int'(pwm_hi[0] !== 1'b0);
      cyc(1);
    end
    `CHK("pwm_period", 1'b1, pwm_lo[0])
    `CHK("pwm_lo_high", 128 * CARRIER_CYC / 256, h_lo)
    `CHK("pwm_hi_high", 16384 * CARRIER_CYC / 65536, h_hi)
    `CHK("pwm_zero", 0, h_off)
  endtask

  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    cfg = '0;
    irq_clear = '0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(4);
    t_intervals;
    t_remote;
    t_capture;
    t_tape;
    t_frame;
    t_events;
    t_pwm;
    end_of_test;
  end
  // Whole run needs about 2000 clocks; the margin only catches a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test;
  end
endmodule
